// ===== fpc_controller.v
// Purpose: self-programming flash controller: registers, unlock, read, erase, write
// Assumes: register port in the system clock domain; flash array answers reads
//          combinationally and accepts erase and word-program strobes
// Notes:   long erase and write times are module parameters so simulation can shorten them
`include "fpc_map.vh"
`timescale 1ns/1ps
module fpc_controller #(
    parameter ERASE0_CYC = `FPC_T_ERASE0_US * `FPC_CLK_MHZ,
    parameter WRITE0_CYC = `FPC_T_WRITE0_US * `FPC_CLK_MHZ,
    parameter ERASE1_CYC = `FPC_T_ERASE1_US * `FPC_CLK_MHZ,
    parameter WRITE1_CYC = `FPC_T_WRITE1_US * `FPC_CLK_MHZ,
    parameter ENABLE_CYC = `FPC_ENABLE_WINDOW_CYC,
    parameter [15:0] UNLOCK1 = 16'h1234, // arbitrary unlock pattern
    parameter [15:0] UNLOCK2 = 16'h5678, // arbitrary unlock pattern
    parameter [15:0] UNLOCK3 = 16'h9abc  // arbitrary unlock pattern
) (
    input wire clk, // system clock, 20 MHz
    input wire rst, // synchronous reset, high
    input wire [3:0] sfrAddr, // register offset
    input wire sfrWr, // write strobe
    input wire sfrRd, // read strobe
    input wire [7:0] sfrWrData, // write data
    output reg [7:0] sfrRdData, // read data, valid the cycle after sfrRd
    output wire cpuHold, // stall instruction execution
    output reg chipResetReq, // one-cycle whole-chip reset request
    output reg [13:0] flashAddr, // array address for read, erase, program
    input wire [15:0] flashRdData, // array read word
    output reg flashRdEn, // array read in progress
    output reg flashErase, // one-cycle page erase strobe
    output reg flashProgWe, // one-cycle word program strobe
    output reg [15:0] flashProgData // word to program
);
    // sequencer states
    localparam ST_IDLE = 3'h0;
    localparam ST_READ = 3'h1;
    localparam ST_WAIT = 3'h2;
    localparam ST_PROG = 3'h3;
    localparam ST_CLR = 3'h4;

    // software-visible bits
    reg ewEn_q, trig_q, wrStart_q, rdEnable_q, rdStart_q, timeSel_q, bufClr_q;
    reg [2:0] opMode_q;
    reg [7:0] chipPat_q;
    reg [13:0] addr_q;
    reg [7:0] dLo_q [0:3];
    reg [7:0] dHi_q [0:3];
    reg [2:0] state_q;
    reg [16:0] timer_q;
    reg [16:0] target_q;
    reg [10:0] enTimer_q;
    reg [4:0] idx_q;
    reg [7:0] rdMux;
    integer i;

    wire busWr = sfrWr;
    wire wrFd0h = busWr && (sfrAddr == `FPC_OFS_DATA0_HI);
    // byte always stored; load is gated
    wire bufLoad = wrFd0h && ewEn_q && (state_q == ST_IDLE); // see R4
    wire [15:0] bufRd;
    wire clrBusy, clrDone;
    // last word goes out this cycle
    wire progLast = (state_q == ST_PROG) && (idx_q == `FPC_LAST_WORD);
    wire clrReq = busWr && (sfrAddr == `FPC_OFS_CTRL_AUX) && sfrWrData[`FPC_BIT_BUF_CLEAR];
    // a request as a sweep ends restarts it
    wire clrStart = (clrReq && (!bufClr_q || clrDone)) || progLast;
    // pairs 1 to 3 all match in the window
    wire unlockOk = ({dHi_q[1], dLo_q[1]} == UNLOCK1) && ({dHi_q[2], dLo_q[2]} == UNLOCK2) &&
                    ({dHi_q[3], dLo_q[3]} == UNLOCK3);

    // hold the processor whenever an accepted operation runs
    assign cpuHold = (state_q != ST_IDLE); // see R21

    // duration of an erase or write, picked by mode and time select
    function [16:0] opCycles;
        input [2:0] mode;
        input sel;
        begin
            if (mode == `FPC_MODE_ERASE)
                opCycles = sel ? ERASE1_CYC[16:0] : ERASE0_CYC[16:0];
            else
                opCycles = sel ? WRITE1_CYC[16:0] : WRITE0_CYC[16:0];
        end
    endfunction

    // data pair of a data offset
    function [1:0] pairIdx;
        input [3:0] ofs;
        reg [3:0] rel;
        begin
            rel = ofs - `FPC_OFS_DATA0_LO;
            pairIdx = rel[2:1];
        end
    endfunction

    // offset is a data register
    function isData;
        input [3:0] ofs;
        begin
            isData = (ofs >= `FPC_OFS_DATA0_LO) && (ofs <= `FPC_OFS_DATA3_HI);
        end
    endfunction

    // page buffer: load at current word position, read by program sweep
    fpc_write_buffer #(
        .WORDS(32),
        .AW(5),
        .DW(16)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .wrEn(bufLoad),
        .wrIdx(addr_q[4:0]),
        .wrData({sfrWrData, dLo_q[0]}), // see R10
        .rdIdx(idx_q),
        .rdData(bufRd),
        .clrStart(clrStart),
        .clrBusy(clrBusy),
        .clrDone(clrDone)
    );

    // register read multiplexer, unmapped offsets read zero
    always @* begin
        rdMux = 8'h00;
        if (sfrAddr == `FPC_OFS_CTRL_MAIN)
            rdMux = {ewEn_q, opMode_q, trig_q, wrStart_q, rdEnable_q, rdStart_q};
        else if (sfrAddr == `FPC_OFS_CHIP_RST)
            rdMux = chipPat_q;
        else if (sfrAddr == `FPC_OFS_CTRL_AUX)
            rdMux = {6'h00, timeSel_q, bufClr_q};
        else if (sfrAddr == `FPC_OFS_ADDR_LO)
            rdMux = addr_q[7:0];
        else if (sfrAddr == `FPC_OFS_ADDR_HI)
            rdMux = {2'h0, addr_q[13:8]}; // see R17
        else if (isData(sfrAddr)) begin
            if (sfrAddr[0])
                rdMux = dLo_q[pairIdx(sfrAddr)]; // see R15
            else
                rdMux = dHi_q[pairIdx(sfrAddr)];
        end
    end

    // read data register
    always @(posedge clk) begin
        if (rst)
            sfrRdData <= `FPC_RST_BYTE;
        else if (sfrRd)
            sfrRdData <= rdMux;
    end

    // registers, unlock procedure and operation sequencer
    always @(posedge clk) begin
        chipResetReq <= 1'b0;
        flashErase <= 1'b0;
        flashProgWe <= 1'b0;
        if (rst) begin
            ewEn_q <= 1'b0;
            opMode_q <= `FPC_MODE_WRITE;
            trig_q <= 1'b0;
            wrStart_q <= 1'b0;
            rdEnable_q <= 1'b0;
            rdStart_q <= 1'b0;
            timeSel_q <= 1'b0;
            bufClr_q <= 1'b0;
            chipPat_q <= `FPC_RST_BYTE;
            addr_q <= `FPC_RST_ADDR; // see R16
            for (i = 0; i < 4; i = i + 1) begin
                dLo_q[i] <= `FPC_RST_BYTE;
                dHi_q[i] <= `FPC_RST_BYTE;
            end
            state_q <= ST_IDLE;
            timer_q <= 17'h00000;
            target_q <= 17'h00000;
            enTimer_q <= 11'h000;
            idx_q <= 5'h00;
            flashAddr <= `FPC_RST_ADDR;
            flashRdEn <= 1'b0;
            flashProgData <= 16'h0000;
        end else begin
            // software writes; start bits only while idle, never all three at once
            if (busWr && sfrAddr == `FPC_OFS_CTRL_MAIN) begin
                if (!sfrWrData[`FPC_BIT_EW_STATUS])
                    ewEn_q <= 1'b0; // see R20
                opMode_q <= sfrWrData[`FPC_FLD_MODE_HI:`FPC_FLD_MODE_LO];
                if (sfrWrData[`FPC_BIT_TRIGGER] && !trig_q) begin
                    trig_q <= 1'b1; // see R19
                    enTimer_q <= 11'h000;
                end
                if (state_q == ST_IDLE && !(sfrWrData[2] && sfrWrData[1] && sfrWrData[0])) begin
                    wrStart_q <= sfrWrData[`FPC_BIT_WR_START]; // see R5
                    rdEnable_q <= sfrWrData[`FPC_BIT_RD_ENABLE];
                    rdStart_q <= sfrWrData[`FPC_BIT_RD_START]; // see R6
                end
            end
            // one pulse per match
            if (busWr && sfrAddr == `FPC_OFS_CHIP_RST) begin
                chipPat_q <= sfrWrData;
                chipResetReq <= (sfrWrData == `FPC_CHIP_RST_VALUE);
            end
            // time select, clear request
            if (busWr && sfrAddr == `FPC_OFS_CTRL_AUX) begin
                timeSel_q <= sfrWrData[`FPC_BIT_TIME_SEL];
                if (sfrWrData[`FPC_BIT_BUF_CLEAR])
                    bufClr_q <= 1'b1; // see R8
            end
            if (busWr && sfrAddr == `FPC_OFS_ADDR_LO)
                addr_q[7:0] <= sfrWrData;
            // top two bits not kept
            if (busWr && sfrAddr == `FPC_OFS_ADDR_HI)
                addr_q[13:8] <= sfrWrData[5:0];
            if (busWr && isData(sfrAddr)) begin
                if (sfrAddr[0])
                    dLo_q[pairIdx(sfrAddr)] <= sfrWrData;
                else
                    dHi_q[pairIdx(sfrAddr)] <= sfrWrData;
            end
            // each buffer load moves to the next word but never leaves the page
            if (bufLoad && addr_q[4:0] != `FPC_LAST_WORD)
                addr_q <= addr_q + 14'h0001; // see R11, R12
            // clear bit falls once the sweep is over, unless a new request lands with it
            if (clrDone && !clrReq)
                bufClr_q <= 1'b0; // see R8
            // unlock window timer; set of the status wins over a same-cycle clear
            if (trig_q) begin
                if (enTimer_q == ENABLE_CYC[10:0] - 11'h001) begin
                    trig_q <= 1'b0; // see R19
                    enTimer_q <= 11'h000;
                end else begin
                    enTimer_q <= enTimer_q + 11'h001;
                end
                if (opMode_q == `FPC_MODE_ENABLE && unlockOk)
                    ewEn_q <= 1'b1; // see R4
            end
            // operation sequencer
            case (state_q)
            ST_IDLE: begin
                // refused starts fall at once
                timer_q <= 17'h00000;
                if (wrStart_q) begin
                    if (ewEn_q && !clrBusy &&
                        (opMode_q == `FPC_MODE_WRITE || opMode_q == `FPC_MODE_ERASE)) begin
                        target_q <= opCycles(opMode_q, timeSel_q);
                        flashAddr <= {addr_q[13:5], 5'h00}; // see R7
                        state_q <= ST_WAIT;
                    end else begin
                        wrStart_q <= 1'b0;
                    end
                end else if (rdStart_q) begin
                    if (rdEnable_q && opMode_q == `FPC_MODE_READ) begin // see R18
                        flashAddr <= addr_q; // see R2
                        flashRdEn <= 1'b1;
                        state_q <= ST_READ;
                    end else begin
                        rdStart_q <= 1'b0;
                    end
                end
            end
            ST_READ: begin
                // fixed read, word taken last
                timer_q <= timer_q + 17'h00001;
                if (timer_q == `FPC_READ_CYC - 1) begin
                    dLo_q[0] <= flashRdData[7:0]; // see R22
                    dHi_q[0] <= flashRdData[15:8];
                    flashRdEn <= 1'b0;
                    rdStart_q <= 1'b0; // see R6
                    state_q <= ST_IDLE;
                end
            end
            ST_WAIT: begin
                // erase or write time
                timer_q <= timer_q + 17'h00001;
                if (timer_q == target_q - 17'h00001) begin
                    idx_q <= 5'h00;
                    if (opMode_q == `FPC_MODE_ERASE) begin
                        flashErase <= 1'b1; // see R1
                        wrStart_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_PROG;
                    end
                end
            end
            ST_PROG: begin
                // program the whole page from the buffer, one word a cycle
                flashProgWe <= 1'b1; // see R1
                flashAddr <= {addr_q[13:5], idx_q};
                flashProgData <= bufRd;
                idx_q <= idx_q + 5'h01;
                if (progLast)
                    state_q <= ST_CLR; // see R13
            end
            ST_CLR: begin
                // hold until buffer empty
                if (clrDone) begin
                    wrStart_q <= 1'b0; // see R5
                    state_q <= ST_IDLE;
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== fpc_controller_props.sv
// Purpose: concurrent checks on the ports of the self-programming flash controller
// Assumes: single clock domain, synchronous active-high reset
// Notes:   long runs are counted in helper logic instead of long repetitions
`include "fpc_map.vh"
`timescale 1ns/1ps
module fpc_controller_props (
    input wire clk, // system clock
    input wire rst, // synchronous reset, high
    input wire [3:0] sfrAddr, // register offset
    input wire sfrWr, // write strobe
    input wire sfrRd, // read strobe
    input wire [7:0] sfrWrData, // write data
    input wire [7:0] sfrRdData, // read data
    input wire cpuHold, // execution stall
    input wire chipResetReq, // whole-chip reset pulse
    input wire [13:0] flashAddr, // array address
    input wire flashRdEn, // array read level
    input wire flashErase, // erase strobe
    input wire flashProgWe // program strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // length of the current run of program strobes
    reg [5:0] progRun_q;
    always @(posedge clk) begin
        if (rst || !flashProgWe)
            progRun_q <= 6'h00;
        else
            progRun_q <= progRun_q + 6'h01;
    end

    // a read is exactly four cycles of enable, counted from its rise, then a low
    sequence s_rdBegin;
        $rose(flashRdEn);
    endsequence
    sequence s_rdBody;
        flashRdEn [*4] ##1 !flashRdEn;
    endsequence

    property p_rdLen;
        s_rdBegin |-> s_rdBody;
    endproperty
    property p_rdHold;
        flashRdEn |-> cpuHold;
    endproperty
    property p_rdEnd;
        $fell(flashRdEn) |-> !cpuHold;
    endproperty
    property p_progHold;
        flashProgWe |-> cpuHold;
    endproperty
    property p_burst;
        $fell(flashProgWe) |-> progRun_q == 6'h20;
    endproperty
    property p_progStep;
        flashProgWe && $past(flashProgWe) |-> flashAddr == $past(flashAddr) + 14'h0001;
    endproperty
    property p_eraseBase;
        flashErase |-> flashAddr[4:0] == 5'h00 ##1 !flashErase;
    endproperty
    property p_chipRst;
        sfrWr && sfrAddr == `FPC_OFS_CHIP_RST && sfrWrData == `FPC_CHIP_RST_VALUE
            |=> chipResetReq ##1 !chipResetReq;
    endproperty
    property p_hiRead;
        sfrRd && sfrAddr == `FPC_OFS_ADDR_HI |=> sfrRdData[7:6] == 2'b00;
    endproperty
    property p_unmapped;
        sfrRd && sfrAddr > `FPC_OFS_DATA3_HI |=> sfrRdData == 8'h00;
    endproperty

    a_rdLen: assert property (p_rdLen) else $error("read enable not four cycles");
    a_rdHold: assert property (p_rdHold) else $error("read without stall");
    a_rdEnd: assert property (p_rdEnd) else $error("stall outlives read");
    a_progHold: assert property (p_progHold) else $error("program without stall");
    a_burst: assert property (p_burst) else $error("program burst not one page");
    a_progStep: assert property (p_progStep) else $error("program address skips");
    a_eraseBase: assert property (p_eraseBase) else $error("erase not at page base");
    a_chipRst: assert property (p_chipRst) else $error("chip reset pulse wrong");
    a_hiRead: assert property (p_hiRead) else $error("address high top bits set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind fpc_controller fpc_controller_props u_props (.clk(clk), .rst(rst), .sfrAddr(sfrAddr),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .cpuHold(cpuHold), .chipResetReq(chipResetReq), .flashAddr(flashAddr),
    .flashRdEn(flashRdEn), .flashErase(flashErase), .flashProgWe(flashProgWe));

// ===== fpc_controller_tb.sv
// Purpose: self-checking bench for the self-programming flash controller
// Assumes: short erase, write and unlock times; flash array is a fixed map of the address
// Notes:   register accesses are spaced one idle cycle apart
`include "fpc_map.vh"
`timescale 1ns/1ps
module fpc_controller_tb;
    localparam [15:0] PAT1 = 16'h1234; // arbitrary unlock pattern
    localparam [15:0] PAT2 = 16'h5678; // arbitrary unlock pattern
    localparam [15:0] PAT3 = 16'h9abc; // arbitrary unlock pattern
    localparam ENW = 64;
    reg clk, rst, sfrWr, sfrRd;
    reg [3:0] sfrAddr;
    reg [7:0] sfrWrData, rv;
    reg [15:0] flashRdData = 16'h0000;
    wire [7:0] sfrRdData;
    wire cpuHold, chipResetReq, flashRdEn, flashErase, flashProgWe;
    wire [13:0] flashAddr;
    wire [15:0] flashProgData;
    reg [15:0] progBuf [0:31];
    reg [13:0] eraseAddr;
    integer mismatches, nTests, nProg, nRst, badPage, i;

    fpc_controller #(.ERASE0_CYC(8), .WRITE0_CYC(8), .ERASE1_CYC(8), .WRITE1_CYC(8),
        .ENABLE_CYC(ENW), .UNLOCK1(PAT1), .UNLOCK2(PAT2), .UNLOCK3(PAT3)) dut (
        .clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .cpuHold(cpuHold),
        .chipResetReq(chipResetReq), .flashAddr(flashAddr), .flashRdData(flashRdData),
        .flashRdEn(flashRdEn), .flashErase(flashErase), .flashProgWe(flashProgWe),
        .flashProgData(flashProgData));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // array model plus capture of program, erase and reset traffic
    always @(posedge clk) begin
        flashRdData <= {flashAddr[7:0], 2'b10, flashAddr[13:8]};
        if (flashProgWe) begin
            progBuf[flashAddr[4:0]] <= flashProgData;
            nProg <= nProg + 1;
            if (flashAddr[13:5] !== 9'h008) badPage <= badPage + 1;
        end
        if (flashErase) eraseAddr <= flashAddr;
        if (chipResetReq) nRst <= nRst + 1;
    end

    task chk8(input string nm, input [7:0] e, input [7:0] g);
        chk16(nm, {8'h00, e}, {8'h00, g});
    endtask
    task chk16(input string nm, input [15:0] e, input [15:0] g);
        begin
            nTests = nTests + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            sfrAddr <= a;
            sfrWrData <= d;
            sfrWr <= 1'b1;
            @(posedge clk);
            sfrWr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clk);
            sfrAddr <= a;
            sfrRd <= 1'b1;
            @(posedge clk);
            sfrRd <= 1'b0;
            @(negedge clk);
            d = sfrRdData;
        end
    endtask
    task rchk(input [3:0] a, input [7:0] e, input string nm);
        begin
            rd(a, rv);
            chk8(nm, e, rv);
        end
    endtask
    // poll one status bit until hardware clears it
    task waitLow(input [3:0] a, input integer b, input string nm);
        integer k;
        begin
            rd(a, rv);
            for (k = 0; k < 300 && rv[b] !== 1'b0; k = k + 1) rd(a, rv);
            chk8(nm, 8'h00, {7'h00, rv[b]});
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", nTests, mismatches);
            if (mismatches == 0 && nTests > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        results;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        sfrWr = 1'b0;
        sfrRd = 1'b0;
        sfrAddr = 4'h0;
        sfrWrData = 8'h00;
        mismatches = 0;
        nTests = 0;
        nProg = 0;
        nRst = 0;
        badPage = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i = i + 1) rchk(i[3:0], 8'h00, "reset value");
        wr(`FPC_OFS_ADDR_HI, 8'hc1);
        rchk(`FPC_OFS_ADDR_HI, 8'h01, "address high");
        wr(`FPC_OFS_ADDR_LO, 8'h1e);
        wr(`FPC_OFS_DATA0_LO, 8'h11);
        wr(`FPC_OFS_DATA0_HI, 8'h22);
        rchk(`FPC_OFS_ADDR_LO, 8'h1e, "load while locked");
        wr(`FPC_OFS_CHIP_RST, 8'h54);
        wr(`FPC_OFS_CHIP_RST, 8'h55);
        repeat (2) @(posedge clk);
        chk16("chip reset pulses", 16'h0001, nRst[15:0]);
        // unlock, then let the procedure timer run out
        wr(`FPC_OFS_CTRL_MAIN, 8'h68);
        wr(`FPC_OFS_DATA1_LO, PAT1[7:0]);
        wr(`FPC_OFS_DATA1_HI, PAT1[15:8]);
        wr(`FPC_OFS_DATA2_LO, PAT2[7:0]);
        wr(`FPC_OFS_DATA2_HI, PAT2[15:8]);
        wr(`FPC_OFS_DATA3_LO, PAT3[7:0]);
        wr(`FPC_OFS_DATA3_HI, PAT3[15:8]);
        rchk(`FPC_OFS_CTRL_MAIN, 8'he8, "unlock status");
        repeat (ENW) @(posedge clk);
        rchk(`FPC_OFS_CTRL_MAIN, 8'he0, "trigger timeout");
        // clear buffer, load the last two words of page 8, then program
        wr(`FPC_OFS_CTRL_AUX, 8'h01);
        rchk(`FPC_OFS_CTRL_AUX, 8'h01, "clear busy");
        waitLow(`FPC_OFS_CTRL_AUX, 0, "clear done");
        wr(`FPC_OFS_CTRL_MAIN, 8'h94);
        waitLow(`FPC_OFS_CTRL_MAIN, 2, "first erase");
        wr(`FPC_OFS_CTRL_MAIN, 8'h80);
        wr(`FPC_OFS_DATA0_HI, 8'h22);
        rchk(`FPC_OFS_ADDR_LO, 8'h1f, "address step");
        wr(`FPC_OFS_DATA0_LO, 8'h33);
        wr(`FPC_OFS_DATA0_HI, 8'h44);
        rchk(`FPC_OFS_ADDR_LO, 8'h1f, "address hold");
        rchk(`FPC_OFS_ADDR_HI, 8'h01, "address high kept");
        wr(`FPC_OFS_CTRL_MAIN, 8'h84);
        rchk(`FPC_OFS_CTRL_MAIN, 8'h84, "write busy");
        chk8("hold while busy", 8'h01, {7'h00, cpuHold});
        waitLow(`FPC_OFS_CTRL_MAIN, 2, "write done");
        chk16("words programmed", 16'h0020, nProg[15:0]);
        chk16("word 30", 16'h2211, progBuf[30]);
        chk16("word 31", 16'h4433, progBuf[31]);
        chk16("word 0", `FPC_ERASED_WORD, progBuf[0]);
        chk16("page of program", 16'h0000, badPage[15:0]);
        // second program with no loads must see an emptied buffer
        wr(`FPC_OFS_CTRL_MAIN, 8'h84);
        waitLow(`FPC_OFS_CTRL_MAIN, 2, "rewrite done");
        for (i = 0; i < 32; i = i + 1) chk16("auto clear", `FPC_ERASED_WORD, progBuf[i]);
        // failed verify: clear, reload one word, program again
        wr(`FPC_OFS_CTRL_AUX, 8'h01);
        waitLow(`FPC_OFS_CTRL_AUX, 0, "reclear done");
        wr(`FPC_OFS_DATA0_HI, 8'h55);
        wr(`FPC_OFS_CTRL_MAIN, 8'h84);
        waitLow(`FPC_OFS_CTRL_MAIN, 2, "reload done");
        chk16("reloaded word", 16'h5533, progBuf[31]);
        // page erase with the longer time selected
        wr(`FPC_OFS_CTRL_AUX, 8'h02);
        rchk(`FPC_OFS_CTRL_AUX, 8'h02, "time select");
        wr(`FPC_OFS_CTRL_MAIN, 8'h94);
        waitLow(`FPC_OFS_CTRL_MAIN, 2, "erase done");
        chk16("erase page", 16'h0100, {2'b00, eraseAddr});
        // start without read enable is dropped; status bit only clears
        wr(`FPC_OFS_ADDR_LO, 8'h23);
        wr(`FPC_OFS_CTRL_MAIN, 8'h31);
        rchk(`FPC_OFS_CTRL_MAIN, 8'h30, "read refused");
        wr(`FPC_OFS_CTRL_MAIN, 8'hb0);
        rchk(`FPC_OFS_CTRL_MAIN, 8'h30, "status write one");
        wr(`FPC_OFS_CTRL_MAIN, 8'h32);
        wr(`FPC_OFS_CTRL_MAIN, 8'h33);
        waitLow(`FPC_OFS_CTRL_MAIN, 0, "read done");
        rchk(`FPC_OFS_DATA0_LO, 8'h81, "read low byte");
        rchk(`FPC_OFS_DATA0_HI, 8'h23, "read high byte");
        results;
    end
endmodule

// ===== fpc_map.vh
// Purpose: register offsets, field positions, reset values and timing figures of the
//          self-programming flash controller
// Assumes: 20 MHz system clock, 8-bit special-function register port
// Notes:   erase and write times are given in microseconds, read and unlock window in cycles; cycle counts are derived in the controller
// Behaviour
// R1 - erase and program work on whole pages; page and buffer hold 32 words
// R2 - one read returns one 16-bit word at the current flash address
// R3 - software should erase a page before programming it
// R4 - enabled status rises only after the unlock procedure; buffer loads need it
// R5 - write-start set by software, held while busy, cleared by hardware at end
// R6 - software sets read-enable then read-start; hardware clears read-start after read
// R7 - address bits 13..5 give page 0..511, bits 4..0 the word in page
// R8 - buffer-clear bit empties the buffer and hardware clears it when done
// R9 - software should clear the buffer before first use and before replacing data
// R10 - writing word0 high byte loads both held bytes as one word into buffer
// R11 - each buffer load increments the address and writes it back to both registers
// R12 - at word position all ones the address stops at the page's last word
// R13 - a finished programming operation empties the write buffer automatically
// R14 - on bad read-back software clears the buffer and reloads before reprogramming
// R15 - words move 16 bits at a time through paired low and high data registers
// R16 - address is 14 bits split high 13..8 and low 7..0, both reset zero
// R17 - high address register bits 7 and 6 always read as zero
// R18 - mode 000 write, 001 page erase, 011 read, 110 enable; rest reserved
// R19 - trigger bit starts a timer; unlock patterns in pairs 1..3; timeout clears it
// R20 - software clearing the enabled status disables erase and write; writing one ignored
// R21 - instruction execution halts while a started read, write or erase runs
// R22 - a finished read places the word into the first data register pair
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// register offsets on the special-function port
`define FPC_OFS_CTRL_MAIN 4'h0
`define FPC_OFS_CHIP_RST 4'h1
`define FPC_OFS_CTRL_AUX 4'h2
`define FPC_OFS_ADDR_LO 4'h3
`define FPC_OFS_ADDR_HI 4'h4
`define FPC_OFS_DATA0_LO 4'h5
`define FPC_OFS_DATA0_HI 4'h6
`define FPC_OFS_DATA1_LO 4'h7
`define FPC_OFS_DATA1_HI 4'h8
`define FPC_OFS_DATA2_LO 4'h9
`define FPC_OFS_DATA2_HI 4'ha
`define FPC_OFS_DATA3_LO 4'hb
`define FPC_OFS_DATA3_HI 4'hc

// main control fields
`define FPC_BIT_EW_STATUS 7
`define FPC_FLD_MODE_HI 6
`define FPC_FLD_MODE_LO 4
`define FPC_BIT_TRIGGER 3
`define FPC_BIT_WR_START 2
`define FPC_BIT_RD_ENABLE 1
`define FPC_BIT_RD_START 0
// aux control fields
`define FPC_BIT_TIME_SEL 1
`define FPC_BIT_BUF_CLEAR 0

// operation modes
`define FPC_MODE_WRITE 3'h0
`define FPC_MODE_ERASE 3'h1
`define FPC_MODE_READ 3'h3
`define FPC_MODE_ENABLE 3'h6

// reset values and special values
`define FPC_RST_BYTE 8'h00
`define FPC_RST_ADDR 14'h0000
`define FPC_CHIP_RST_VALUE 8'h55
`define FPC_ERASED_WORD 16'hffff
`define FPC_LAST_WORD 5'h1f

// timing
`define FPC_CLK_MHZ 20
`define FPC_T_ERASE0_US 3200
`define FPC_T_WRITE0_US 2200
`define FPC_T_ERASE1_US 3700
`define FPC_T_WRITE1_US 3000
`define FPC_READ_CYC 4
`define FPC_ENABLE_WINDOW_CYC 1024

`endif

// ===== fpc_write_buffer.v
// Purpose: page-sized write buffer with a word-at-a-time clear sweep
// Assumes: one write port and one combinational read port, same clock
// Notes:   clearing fills every word with the erased value, one word a cycle
`include "fpc_map.vh"
`timescale 1ns/1ps
module fpc_write_buffer #(
    parameter WORDS = 32,
    parameter AW = 5,
    parameter DW = 16
) (
    input wire clk, // system clock
    input wire rst, // synchronous reset, high
    input wire wrEn, // load one word
    input wire [AW-1:0] wrIdx, // word position for the load
    input wire [DW-1:0] wrData, // word to load
    input wire [AW-1:0] rdIdx, // word position to read
    output wire [DW-1:0] rdData, // word at rdIdx
    input wire clrStart, // begin a clear sweep
    output wire clrBusy, // sweep in progress
    output reg clrDone // one-cycle pulse at sweep end
);
    reg [DW-1:0] mem [0:WORDS-1];
    reg clrBusy_q;
    reg [AW-1:0] clrIdx_q;

    assign rdData = mem[rdIdx];
    assign clrBusy = clrBusy_q;

    // sweep counter: a load during a sweep is dropped by the sweep overwrite order
    always @(posedge clk) begin
        clrDone <= 1'b0;
        if (rst) begin
            clrBusy_q <= 1'b0;
            clrIdx_q <= {AW{1'b0}};
        end else if (clrBusy_q) begin
            if (clrIdx_q == WORDS[AW-1:0] - 1'b1) begin
                clrBusy_q <= 1'b0;
                clrDone <= 1'b1;
            end
            clrIdx_q <= clrIdx_q + 1'b1;
        end else if (clrStart) begin
            clrBusy_q <= 1'b1;
            clrIdx_q <= {AW{1'b0}};
        end
    end

    // storage: sweep has priority over a load
    always @(posedge clk) begin
        if (clrBusy_q)
            mem[clrIdx_q] <= `FPC_ERASED_WORD; // see R8
        else if (wrEn)
            mem[wrIdx] <= wrData;
    end
endmodule
